/* hw/tlbm_pkg.sv */
// Constants and types of the translation-buffer maintenance block.
// Assumes one core clock; the 32-bit instruction word is presented already fetched.
package tlbm_pkg;
	localparam int TLBM_ENTRIES = 16;
	localparam int TLBM_IDX_W = 4;
	// Instruction fields
	localparam int TLBM_OPC_POS = 26;
	localparam int TLBM_OPC_W = 6;
	localparam logic [5:0] TLBM_OPC_SYS = 6'h10;
	localparam int TLBM_COP_FLAG_POS = 25;
	localparam int TLBM_ZERO_POS = 6;
	localparam int TLBM_ZERO_W = 19;
	localparam int TLBM_FUNC_W = 6;
	localparam logic [5:0] TLBM_FUNC_PROBE = 6'h08;
	localparam logic [5:0] TLBM_FUNC_READ = 6'h01;
	localparam logic [5:0] TLBM_FUNC_WR_IDX = 6'h02;
	localparam logic [5:0] TLBM_FUNC_WR_RND = 6'h06;
	// Staging register fields
	localparam int TLBM_PAGE_PAIR_POS = 13;
	localparam int TLBM_PAGE_PAIR_W = 19;
	localparam int TLBM_SPACE_ID_POS = 0;
	localparam int TLBM_SPACE_ID_W = 8;
	localparam int TLBM_FRAME_NUM_POS = 6;
	localparam int TLBM_FRAME_NUM_W = 20;
	localparam int TLBM_C_POS = 3;
	localparam int TLBM_C_W = 3;
	localparam int TLBM_D_POS = 2;
	localparam int TLBM_V_POS = 1;
	localparam int TLBM_G_POS = 0;
	localparam int TLBM_MASK_POS = 13;
	localparam int TLBM_MASK_W = 12;
	localparam int TLBM_MISS_POS = 31;
	// Writable bits of each staging register, and the cleared register value
	localparam logic [31:0] TLBM_WR_INDEX = 32'h0000000f;
	localparam logic [31:0] TLBM_WR_TAG = 32'hffffe0ff;
	localparam logic [31:0] TLBM_WR_FRAME = 32'h03ffffff;
	localparam logic [31:0] TLBM_WR_MASK = 32'h01ffe000;
	localparam logic [31:0] TLBM_RST_REG = 32'h00000000;
	// Staging register select codes
	localparam logic [2:0] TLBM_SEL_INDEX = 3'h0;
	localparam logic [2:0] TLBM_SEL_TAG = 3'h1;
	localparam logic [2:0] TLBM_SEL_EVEN = 3'h2;
	localparam logic [2:0] TLBM_SEL_ODD = 3'h3;
	localparam logic [2:0] TLBM_SEL_MASK = 3'h4;
	// Set for a block-address-translation organisation
	localparam logic TLBM_BLOCK_XLATE_ORG = 1'b0;

	typedef struct packed {
		logic [TLBM_MASK_W-1:0] mask;
		logic [TLBM_PAGE_PAIR_W-1:0] virtual_page_pair_tag;
		logic [TLBM_SPACE_ID_W-1:0] address_space_id;
		logic g;
		logic [TLBM_FRAME_NUM_W-1:0] page_frame_number1;
		logic [TLBM_C_W-1:0] c1;
		logic d1;
		logic v1;
		logic [TLBM_FRAME_NUM_W-1:0] page_frame_number0;
		logic [TLBM_C_W-1:0] c0;
		logic d0;
		logic v0;
	} tlbm_entry_s;

	typedef logic [TLBM_IDX_W-1:0] tlbm_idx_t;
endpackage

/* hw/tlbm_probe_if.sv */
// Bundle between the maintenance block and its associative match unit.
// Assumes both ends share the core clock; the bundle is purely combinational.
`timescale 1ns/100ps
interface tlbm_probe_if;
	tlbm_pkg::tlbm_entry_s entries [tlbm_pkg::TLBM_ENTRIES];
	logic [tlbm_pkg::TLBM_PAGE_PAIR_W-1:0] tag_page_pair;
	logic [tlbm_pkg::TLBM_SPACE_ID_W-1:0] tag_space_id;
	logic hit;
	tlbm_pkg::tlbm_idx_t hit_idx;
	modport owner (output entries, output tag_page_pair, output tag_space_id, input hit, input hit_idx);
	modport matcher (input entries, input tag_page_pair, input tag_space_id, output hit, output hit_idx);
endinterface

/* hw/tlbm_match.sv */
// Associative compare of the page tag against every buffer entry.
// Assumes at most one entry matches; with several, the lowest index is reported.
`timescale 1ns/100ps
module tlbm_match (
	tlbm_probe_if.matcher p
);
	logic [tlbm_pkg::TLBM_ENTRIES-1:0] match;

	genvar gi;
	generate
		for (gi = 0; gi < tlbm_pkg::TLBM_ENTRIES; gi++) begin : g_cmp
			logic [tlbm_pkg::TLBM_PAGE_PAIR_W-1:0] care;
			assign care = ~{{(tlbm_pkg::TLBM_PAGE_PAIR_W - tlbm_pkg::TLBM_MASK_W){1'b0}}, p.entries[gi].mask};
			// Global entries ignore the address-space id
			assign match[gi] = (((p.entries[gi].virtual_page_pair_tag ^ p.tag_page_pair) & care) == '0) &&
				(p.entries[gi].g || (p.entries[gi].address_space_id == p.tag_space_id));
		end
	endgenerate

	always_comb begin
		p.hit = 1'b0;
		p.hit_idx = '0;
		for (int i = tlbm_pkg::TLBM_ENTRIES - 1; i >= 0; i--) begin
			if (match[i]) begin
				p.hit = 1'b1;
				p.hit_idx = tlbm_pkg::tlbm_idx_t'(i);
			end
		end
	end
endmodule

/* hw/tlbm_maint.sv */
// Translation-buffer maintenance: probe, indexed read, indexed and random write.
// Assumes a decoded-stage instruction word with valid, a coprocessor-usable level,
// and a replacement counter supplied from outside.
// Function
// - Decode only system opcode 010000, bit 25 set, bits 24..6 zero.
// - Probe loads the index register with the matching entry position.
// - A probe miss sets the top bit of the index register.
// - Indexed read copies the selected entry into tag, frame and mask registers.
// - Indexed read returns the single global bit into both frame registers.
// - With block-address translation, read returns zero address-space id.
// - Indexed write fills the entry selected by the index register.
// - Written global bit is the AND of both frame global bits.
// - Random write fills the entry chosen by the replacement register.
`timescale 1ns/100ps
module tlbm_maint (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_instr_valid,
	input wire logic [31:0] i_instr,
	input wire logic i_cop_usable,
	input wire logic [tlbm_pkg::TLBM_IDX_W-1:0] i_random_idx,
	input wire logic i_stage_wr,
	input wire logic [2:0] i_stage_sel,
	input wire logic [31:0] i_stage_data,
	output logic [31:0] o_index,
	output logic [31:0] o_page_tag,
	output logic [31:0] o_even_frame,
	output logic [31:0] o_odd_frame,
	output logic [31:0] o_page_mask,
	output logic o_done,
	output logic o_cop_unusable
);
	typedef struct packed {
		logic [31:0] index;
		logic [31:0] page_tag;
		logic [31:0] even;
		logic [31:0] odd;
		logic [31:0] mask;
		logic done;
		logic unusable;
	} tlbm_state_s;

	tlbm_state_s st_q;
	tlbm_state_s st_d;
	tlbm_pkg::tlbm_entry_s tlb_q [tlbm_pkg::TLBM_ENTRIES];
	tlbm_pkg::tlbm_entry_s wr_entry;
	tlbm_pkg::tlbm_entry_s rd_entry;
	tlbm_pkg::tlbm_idx_t wr_idx;
	tlbm_pkg::tlbm_idx_t idx;
	logic wr_en;
	logic is_sys;
	logic is_op;
	logic do_op;
	logic [5:0] func;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	tlbm_probe_if probe_bus ();

	tlbm_match u_match (
		.p(probe_bus.matcher)
	);

	assign probe_bus.entries = tlb_q;
	assign probe_bus.tag_page_pair = st_q.page_tag[tlbm_pkg::TLBM_PAGE_PAIR_POS +: tlbm_pkg::TLBM_PAGE_PAIR_W];
	assign probe_bus.tag_space_id = st_q.page_tag[tlbm_pkg::TLBM_SPACE_ID_POS +: tlbm_pkg::TLBM_SPACE_ID_W];

	// Decode
	assign func = i_instr[tlbm_pkg::TLBM_FUNC_W-1:0];
	assign is_sys = i_instr_valid &&
		(i_instr[tlbm_pkg::TLBM_OPC_POS +: tlbm_pkg::TLBM_OPC_W] == tlbm_pkg::TLBM_OPC_SYS) &&
		i_instr[tlbm_pkg::TLBM_COP_FLAG_POS] &&
		(i_instr[tlbm_pkg::TLBM_ZERO_POS +: tlbm_pkg::TLBM_ZERO_W] == '0);
	assign is_op = is_sys && ((func == tlbm_pkg::TLBM_FUNC_PROBE) || (func == tlbm_pkg::TLBM_FUNC_READ) ||
		(func == tlbm_pkg::TLBM_FUNC_WR_IDX) || (func == tlbm_pkg::TLBM_FUNC_WR_RND));
	assign do_op = is_op && i_cop_usable;

	// Out-of-range indices cannot occur: the index field is exactly as wide as the array
	assign idx = st_q.index[tlbm_pkg::TLBM_IDX_W-1:0];
	assign rd_entry = tlb_q[idx];

	// Entry assembled from the staging registers
	always_comb begin
		wr_entry.mask = st_q.mask[tlbm_pkg::TLBM_MASK_POS +: tlbm_pkg::TLBM_MASK_W];
		wr_entry.virtual_page_pair_tag =
			st_q.page_tag[tlbm_pkg::TLBM_PAGE_PAIR_POS +: tlbm_pkg::TLBM_PAGE_PAIR_W];
		wr_entry.address_space_id =
			st_q.page_tag[tlbm_pkg::TLBM_SPACE_ID_POS +: tlbm_pkg::TLBM_SPACE_ID_W];
		wr_entry.g = st_q.even[tlbm_pkg::TLBM_G_POS] & st_q.odd[tlbm_pkg::TLBM_G_POS];
		wr_entry.page_frame_number1 =
			st_q.odd[tlbm_pkg::TLBM_FRAME_NUM_POS +: tlbm_pkg::TLBM_FRAME_NUM_W];
		wr_entry.c1 = st_q.odd[tlbm_pkg::TLBM_C_POS +: tlbm_pkg::TLBM_C_W];
		wr_entry.d1 = st_q.odd[tlbm_pkg::TLBM_D_POS];
		wr_entry.v1 = st_q.odd[tlbm_pkg::TLBM_V_POS];
		wr_entry.page_frame_number0 =
			st_q.even[tlbm_pkg::TLBM_FRAME_NUM_POS +: tlbm_pkg::TLBM_FRAME_NUM_W];
		wr_entry.c0 = st_q.even[tlbm_pkg::TLBM_C_POS +: tlbm_pkg::TLBM_C_W];
		wr_entry.d0 = st_q.even[tlbm_pkg::TLBM_D_POS];
		wr_entry.v0 = st_q.even[tlbm_pkg::TLBM_V_POS];
	end

	assign wr_en = do_op && ((func == tlbm_pkg::TLBM_FUNC_WR_IDX) || (func == tlbm_pkg::TLBM_FUNC_WR_RND));
	assign wr_idx = (func == tlbm_pkg::TLBM_FUNC_WR_RND) ? i_random_idx : idx;

	always_comb begin
		st_d = st_q;
		st_d.done = do_op;
		st_d.unusable = is_op && !i_cop_usable;
		// Software staging write; a read in the same cycle overrides it, except a write to the index register
		if (i_stage_wr) begin
			case (i_stage_sel)
				tlbm_pkg::TLBM_SEL_INDEX: st_d.index = (st_q.index & ~tlbm_pkg::TLBM_WR_INDEX) |
					(i_stage_data & tlbm_pkg::TLBM_WR_INDEX);
				tlbm_pkg::TLBM_SEL_TAG: st_d.page_tag = i_stage_data & tlbm_pkg::TLBM_WR_TAG;
				tlbm_pkg::TLBM_SEL_EVEN: st_d.even = i_stage_data & tlbm_pkg::TLBM_WR_FRAME;
				tlbm_pkg::TLBM_SEL_ODD: st_d.odd = i_stage_data & tlbm_pkg::TLBM_WR_FRAME;
				tlbm_pkg::TLBM_SEL_MASK: st_d.mask = i_stage_data & tlbm_pkg::TLBM_WR_MASK;
				default: st_d = st_d;
			endcase
		end
		if (do_op) begin
			case (func)
				tlbm_pkg::TLBM_FUNC_PROBE: begin
					st_d.index = tlbm_pkg::TLBM_RST_REG;
					if (probe_bus.hit) begin
						st_d.index[tlbm_pkg::TLBM_IDX_W-1:0] = probe_bus.hit_idx;
					end else begin
						st_d.index[tlbm_pkg::TLBM_MISS_POS] = 1'b1;
					end
				end
				tlbm_pkg::TLBM_FUNC_READ: begin
					st_d.page_tag = tlbm_pkg::TLBM_RST_REG;
					st_d.page_tag[tlbm_pkg::TLBM_PAGE_PAIR_POS +: tlbm_pkg::TLBM_PAGE_PAIR_W] =
						rd_entry.virtual_page_pair_tag;
					st_d.page_tag[tlbm_pkg::TLBM_SPACE_ID_POS +: tlbm_pkg::TLBM_SPACE_ID_W] =
						tlbm_pkg::TLBM_BLOCK_XLATE_ORG ? '0 : rd_entry.address_space_id;
					st_d.even = tlbm_pkg::TLBM_RST_REG;
					st_d.even[tlbm_pkg::TLBM_FRAME_NUM_POS +: tlbm_pkg::TLBM_FRAME_NUM_W] =
						rd_entry.page_frame_number0;
					st_d.even[tlbm_pkg::TLBM_C_POS +: tlbm_pkg::TLBM_C_W] = rd_entry.c0;
					st_d.even[tlbm_pkg::TLBM_D_POS] = rd_entry.d0;
					st_d.even[tlbm_pkg::TLBM_V_POS] = rd_entry.v0;
					st_d.even[tlbm_pkg::TLBM_G_POS] = rd_entry.g;
					st_d.odd = tlbm_pkg::TLBM_RST_REG;
					st_d.odd[tlbm_pkg::TLBM_FRAME_NUM_POS +: tlbm_pkg::TLBM_FRAME_NUM_W] =
						rd_entry.page_frame_number1;
					st_d.odd[tlbm_pkg::TLBM_C_POS +: tlbm_pkg::TLBM_C_W] = rd_entry.c1;
					st_d.odd[tlbm_pkg::TLBM_D_POS] = rd_entry.d1;
					st_d.odd[tlbm_pkg::TLBM_V_POS] = rd_entry.v1;
					st_d.odd[tlbm_pkg::TLBM_G_POS] = rd_entry.g;
					st_d.mask = tlbm_pkg::TLBM_RST_REG;
					st_d.mask[tlbm_pkg::TLBM_MASK_POS +: tlbm_pkg::TLBM_MASK_W] = rd_entry.mask;
				end
				default: st_d = st_d;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Buffer array; cleared at reset so probes never see unknown tags
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			for (int i = 0; i < tlbm_pkg::TLBM_ENTRIES; i++) begin
				tlb_q[i] <= '0;
			end
		end else if (wr_en) begin
			tlb_q[wr_idx] <= wr_entry;
		end
	end

	assign o_index = st_q.index;
	assign o_page_tag = st_q.page_tag;
	assign o_even_frame = st_q.even;
	assign o_odd_frame = st_q.odd;
	assign o_page_mask = st_q.mask;
	assign o_done = st_q.done;
	assign o_cop_unusable = st_q.unusable;

	a_decode_zero_field: assert property (
		(i_instr_valid && (i_instr[tlbm_pkg::TLBM_ZERO_POS +: tlbm_pkg::TLBM_ZERO_W] != '0))
		|=> !o_done && !o_cop_unusable)
		else $error("Instruction with nonzero middle field acted on");

	a_probe_hit_index: assert property (
		(do_op && (func == tlbm_pkg::TLBM_FUNC_PROBE) && probe_bus.hit)
		|=> (o_index == {28'h0000000, $past(probe_bus.hit_idx)}) && o_done)
		else $error("Probe hit did not load matching index");

	a_probe_miss_flag: assert property (
		(do_op && (func == tlbm_pkg::TLBM_FUNC_PROBE) && !probe_bus.hit)
		|=> o_index[tlbm_pkg::TLBM_MISS_POS])
		else $error("Probe miss did not set top index bit");

	a_read_mask_back: assert property (
		(do_op && (func == tlbm_pkg::TLBM_FUNC_READ))
		|=> o_page_mask[tlbm_pkg::TLBM_MASK_POS +: tlbm_pkg::TLBM_MASK_W] == $past(rd_entry.mask))
		else $error("Indexed read returned wrong page mask");

	a_read_global_both: assert property (
		(do_op && (func == tlbm_pkg::TLBM_FUNC_READ))
		|=> (o_even_frame[tlbm_pkg::TLBM_G_POS] == $past(rd_entry.g)) &&
			(o_odd_frame[tlbm_pkg::TLBM_G_POS] == $past(rd_entry.g)))
		else $error("Indexed read global bits differ from entry");

	// Checks the configured organisation only: zero with block translation, the stored id otherwise
	a_read_space_id: assert property (
		(do_op && (func == tlbm_pkg::TLBM_FUNC_READ))
		|=> o_page_tag[tlbm_pkg::TLBM_SPACE_ID_POS +: tlbm_pkg::TLBM_SPACE_ID_W] ==
			(tlbm_pkg::TLBM_BLOCK_XLATE_ORG ? '0 : $past(rd_entry.address_space_id)))
		else $error("Indexed read returned wrong address-space id");

	a_write_idx_tag: assert property (
		(do_op && (func == tlbm_pkg::TLBM_FUNC_WR_IDX))
		|=> tlb_q[$past(idx)].virtual_page_pair_tag ==
			$past(st_q.page_tag[tlbm_pkg::TLBM_PAGE_PAIR_POS +: tlbm_pkg::TLBM_PAGE_PAIR_W]))
		else $error("Indexed write missed selected entry");

	a_write_global_and: assert property (
		wr_en |=> tlb_q[$past(wr_idx)].g ==
			($past(st_q.even[tlbm_pkg::TLBM_G_POS]) && $past(st_q.odd[tlbm_pkg::TLBM_G_POS])))
		else $error("Stored global bit is not the AND of both");

	a_write_random_slot: assert property (
		(do_op && (func == tlbm_pkg::TLBM_FUNC_WR_RND))
		|=> tlb_q[$past(i_random_idx)].page_frame_number1 ==
			$past(st_q.odd[tlbm_pkg::TLBM_FRAME_NUM_POS +: tlbm_pkg::TLBM_FRAME_NUM_W]))
		else $error("Random write missed replacement entry");

	a_write_even_page: assert property (
		wr_en |=> (tlb_q[$past(wr_idx)].page_frame_number0 ==
			$past(st_q.even[tlbm_pkg::TLBM_FRAME_NUM_POS +: tlbm_pkg::TLBM_FRAME_NUM_W])) &&
			(tlb_q[$past(wr_idx)].v0 == $past(st_q.even[tlbm_pkg::TLBM_V_POS])))
		else $error("Even page fields not stored");

	a_unusable_blocks: assert property (
		(is_op && !i_cop_usable && !i_stage_wr)
		|=> o_cop_unusable && !o_done && $stable(o_index) && $stable(o_page_tag))
		else $error("Operation performed without coprocessor access");
endmodule

/* test/tlbm_issue_model.sv */
// Pipeline-side model that issues the maintenance instruction word with its valid.
// Assumes the bench raises i_req just after a falling edge, for one cycle.
`timescale 1ns/100ps
module tlbm_issue_model (
	input wire logic i_sys_clk,
	input wire logic i_req,
	input wire logic [5:0] i_func,
	input wire logic [31:0] i_extra,
	output logic [31:0] o_instr,
	output logic o_valid
);
	logic [31:0] last_q = 32'h00000000;
	// Idle word keeps toggling so a stale word never passes for a fresh one
	always_ff @(posedge i_sys_clk) begin
		last_q <= o_instr;
	end
	assign o_valid = i_req;
	assign o_instr = i_req ? ({tlbm_pkg::TLBM_OPC_SYS, 1'b1, 19'h00000, i_func} | i_extra) : ~last_q;
endmodule

/* test/testbench.sv */
// Self-checking bench for the translation-buffer maintenance block.
// Assumes the design's 16-entry buffer and staging field layout from its package.
`timescale 1ns/100ps
module testbench;
	typedef struct packed {logic [2:0] sel; logic [31:0] data; logic [31:0] exp;} tlbm_row_s;
	localparam logic [31:0] TAG3 = 32'h1234a045, EVEN3 = 32'h01234567, ODD3 = 32'h0089abce;
	localparam logic [31:0] TAG9 = 32'h8765e021, EVEN9 = 32'h02aa5559, ODD9 = 32'h0155aaa7;
	localparam logic [31:0] MASK9 = 32'h0001e000;
	logic clk = 1'b0, rst = 1'b1, usable = 1'b1, req = 1'b0, swr = 1'b0;
	logic [5:0] func = 6'h00;
	logic [31:0] extra = 32'h00000000, sdata = 32'h00000000;
	logic [31:0] instr, idx, tag, even, odd, mask;
	logic [2:0] ssel = 3'h0;
	logic [3:0] rnd = 4'h0;
	logic valid, done, unus;
	int miscompares = 0;
	int total_checks = 0;
	tlbm_row_s rows [5] = '{
		'{3'h0, 32'hffffffff, 32'h0000000f},
		'{3'h1, 32'hffffffff, 32'hffffe0ff},
		'{3'h2, 32'hffffffff, 32'h03ffffff},
		'{3'h3, 32'hffffffff, 32'h03ffffff},
		'{3'h4, 32'hffffffff, 32'h01ffe000}};

	always #4 clk = ~clk;

	tlbm_issue_model u_tlbm_issue_model (.i_sys_clk(clk), .i_req(req), .i_func(func), .i_extra(extra),
		.o_instr(instr), .o_valid(valid));
	tlbm_maint u_tlbm_maint (.i_sys_clk(clk), .i_sys_rst(rst), .i_instr_valid(valid), .i_instr(instr),
		.i_cop_usable(usable), .i_random_idx(rnd), .i_stage_wr(swr), .i_stage_sel(ssel),
		.i_stage_data(sdata), .o_index(idx), .o_page_tag(tag), .o_even_frame(even), .o_odd_frame(odd),
		.o_page_mask(mask), .o_done(done), .o_cop_unusable(unus));

	task chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task chk1(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask

	function logic [31:0] reg_of(input logic [2:0] s);
		case (s)
			3'h0: return idx;
			3'h1: return tag;
			3'h2: return even;
			3'h3: return odd;
			default: return mask;
		endcase
	endfunction

	task stage(input logic [2:0] s, input logic [31:0] d);
		@(negedge clk);
		swr = 1'b1;
		ssel = s;
		sdata = d;
		@(negedge clk);
		swr = 1'b0;
	endtask

	task op(input logic [5:0] f, input logic [31:0] x, input logic u, input logic edone, input logic eunus);
		@(negedge clk);
		req = 1'b1;
		func = f;
		extra = x;
		usable = u;
		@(negedge clk);
		req = 1'b0;
		usable = 1'b1;
		chk1("done pulse", edone, done);
		chk1("unusable pulse", eunus, unus);
	endtask

	task tally_and_finish;
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Whole run is well under 200 cycles
	initial begin
		#20000;
		miscompares++;
		$display("unexpected run length: expected finish, seen timeout");
		tally_and_finish;
	end

	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 5; i++) chk32("reset register", 32'h00000000, reg_of(i[2:0]));
		chk1("reset done", 1'b0, done);
		$display("test reset finished");
		foreach (rows[i]) begin
			stage(rows[i].sel, rows[i].data);
			chk32("staged register", rows[i].exp, reg_of(rows[i].sel));
		end
		// Select code 5, above the mask register, must leave every register alone
		stage(3'h5, 32'h00000000);
		foreach (rows[i]) chk32("register after unused select", rows[i].exp, reg_of(rows[i].sel));
		$display("test staging finished");
		stage(3'h4, 32'h00000000);
		stage(3'h1, TAG3);
		stage(3'h2, EVEN3);
		stage(3'h3, ODD3);
		stage(3'h0, 32'h00000003);
		op(tlbm_pkg::TLBM_FUNC_WR_IDX, 32'h0, 1'b1, 1'b1, 1'b0);
		stage(3'h1, TAG9);
		stage(3'h2, EVEN9);
		stage(3'h3, ODD9);
		stage(3'h4, MASK9);
		rnd = 4'h9;
		op(tlbm_pkg::TLBM_FUNC_WR_RND, 32'h0, 1'b1, 1'b1, 1'b0);
		stage(3'h1, 32'h00000000);
		op(tlbm_pkg::TLBM_FUNC_WR_IDX, 32'h0, 1'b0, 1'b0, 1'b1);
		op(tlbm_pkg::TLBM_FUNC_READ, 32'h00000400, 1'b1, 1'b0, 1'b0);
		op(6'h20, 32'h0, 1'b1, 1'b0, 1'b0);
		chk32("page tag after refused ops", 32'h00000000, tag);
		$display("test writes and refusals finished");
		op(tlbm_pkg::TLBM_FUNC_READ, 32'h0, 1'b1, 1'b1, 1'b0);
		chk32("read tag", TAG3, tag);
		chk32("read even", EVEN3 & 32'hfffffffe, even);
		chk32("read odd", ODD3, odd);
		chk32("read mask", 32'h00000000, mask);
		stage(3'h0, 32'h00000009);
		op(tlbm_pkg::TLBM_FUNC_READ, 32'h0, 1'b1, 1'b1, 1'b0);
		chk32("read tag", TAG9, tag);
		chk32("read even", EVEN9, even);
		chk32("read odd", ODD9, odd);
		chk32("read mask", MASK9, mask);
		// Staging write in the same cycle as a read: the read must win
		@(negedge clk);
		swr = 1'b1;
		ssel = 3'h1;
		sdata = 32'hffffffff;
		req = 1'b1;
		func = tlbm_pkg::TLBM_FUNC_READ;
		@(negedge clk);
		swr = 1'b0;
		req = 1'b0;
		chk1("done pulse", 1'b1, done);
		chk32("read tag over staging write", TAG9, tag);
		$display("test reads finished");
		stage(3'h0, 32'h00000000);
		op(tlbm_pkg::TLBM_FUNC_PROBE, 32'h0, 1'b1, 1'b1, 1'b0);
		chk32("probe hit index", 32'h00000009, idx);
		stage(3'h1, 32'h55550000);
		op(tlbm_pkg::TLBM_FUNC_PROBE, 32'h0, 1'b1, 1'b1, 1'b0);
		chk32("probe miss index", 32'h80000000, idx);
		stage(3'h0, 32'h00000003);
		chk32("index after miss", 32'h80000003, idx);
		$display("test probes finished");
		// Second reset in mid-run must clear the miss flag and buffer entry 9
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 5; i++) chk32("register after second reset", 32'h00000000, reg_of(i[2:0]));
		chk1("done after second reset", 1'b0, done);
		stage(3'h1, TAG9);
		stage(3'h2, EVEN9);
		stage(3'h0, 32'h00000009);
		op(tlbm_pkg::TLBM_FUNC_READ, 32'h0, 1'b1, 1'b1, 1'b0);
		chk32("tag of cleared entry", 32'h00000000, tag);
		chk32("even of cleared entry", 32'h00000000, even);
		chk32("mask of cleared entry", 32'h00000000, mask);
		$display("test second reset finished");
		tally_and_finish;
	end
endmodule
